// ===== design/periodic_defines.svh
// Register map, field positions and timing for the periodic interrupt unit.
// Assumes a single AHB-Lite slave select per register word.
`ifndef PERIODIC_DEFINES_SVH
`define PERIODIC_DEFINES_SVH
`define OFS_DRIVE      8'h00
`define OFS_ENABLE     8'h04
`define OFS_STATUS     8'h08
`define OFS_IRQ_STAT   8'h0C
`define OFS_IRQ_MASK   8'h10
`define DRV_PEND_BIT   7
`define DRV_CLK_LO     0
`define DRV_HD_LO      2
`define EN_KEY_LO      0
`define EN_IVL_LO      4
`define ST_FLAG_BIT    3
`define ST_ACK_BIT     2
`define ST_MASK_BIT    1
`define ST_MODE_BIT    0
`define IVL_BASE_LOG   4'h8
`define RC_HZ          32768
`define CLK_HZ         10000000
`define HTRANS_NONSEQ  2'h2
`endif

// ===== design/periodic_pkg.sv
// Types shared by the periodic interrupt unit.
// Assumes the defines header is compiled alongside.
package periodic_pkg;
  typedef enum logic [1:0] {
    CLK_RC   = 2'h0,
    CLK_EXT  = 2'h1,
    CLK_OSC  = 2'h2,
    CLK_RSVD = 2'h3
  } clk_sel_t;
  typedef enum logic [2:0] {
    KS_IDLE  = 3'h1,
    KS_ARMED = 3'h2,
    KS_HELD  = 3'h4
  } key_state_t;
endpackage : periodic_pkg

// ===== design/period_counter.sv
// Periodic counter running on one of three clock enables.
// Assumes each enable input is a one-cycle pulse in the MCLK_I domain.
`timescale 1ns/10ps
`default_nettype none
`include "periodic_defines.svh"
module period_counter (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [2:0] ivl_i,
  input  wire logic       rc_tick_i,
  input  wire logic       ext_tick_i,
  input  wire logic       osc_tick_i,
  output logic            hit_o
);
  logic [14:0] count;
  logic        tick;
  logic [14:0] last;

  function automatic logic [14:0] period_last(input logic [2:0] ivl);
    logic [3:0] sh;
    sh = 4'(ivl) + `IVL_BASE_LOG;
    period_last = 15'((16'h0001 << sh) - 16'h0001);
  endfunction : period_last

  always_comb begin
    case (periodic_pkg::clk_sel_t'(sel_i))
      periodic_pkg::CLK_RC:  tick = rc_tick_i;
      periodic_pkg::CLK_EXT: tick = ext_tick_i;
      periodic_pkg::CLK_OSC: tick = osc_tick_i;
      default:               tick = 1'b0;
    endcase
  end

  assign last = period_last(ivl_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || ivl_i == 3'h0) begin
      count <= 15'h0000;
      hit_o <= 1'b0;
    end else begin
      hit_o <= 1'b0;
      if (tick) begin
        if (count >= last) begin
          count <= 15'h0000;
          hit_o <= 1'b1;
        end else begin
          count <= count + 15'h0001;
        end
      end
    end
  end

  off_no_hit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ivl_i == 3'h0) |=> !hit_o) else $error("Hit while disabled");
  wrap_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hit_o |-> count == 15'h0000) else $error("Counter did not restart");
  hit_at_last_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick && ivl_i != 3'h0 && count == last && $stable(ivl_i)) |=> hit_o)
    else $error("Missed period end");
  rsvd_still_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel_i == 2'h3 && ivl_i != 3'h0) |=> $stable(count))
    else $error("Reserved clock counted");
endmodule : period_counter
`default_nettype wire

// ===== design/periodic_interrupt_timer.sv
// Periodic interrupt unit with its shared keypad request path and AHB-Lite registers.
// Assumes MCLK_I at 10 MHz; OSC and external clocks arrive as synchronous levels.
`timescale 1ns/10ps
`default_nettype none
`include "periodic_defines.svh"
module periodic_interrupt_timer (
  input  wire logic        MCLK_I,
  input  wire logic        NRST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        EXT_CLK_I,
  input  wire logic        OSC_CLK_I,
  input  wire logic [3:0]  KEY_PINS_I,
  output logic             KEY_REQ_O,
  output logic [3:0]       HIGH_DRIVE_O,
  output logic             IRQ_O
);
  localparam int RC_DIV = `CLK_HZ / `RC_HZ;

  logic [1:0]  periodic_clock_select;
  logic [3:0]  port_b_high_drive_enables;
  logic [3:0]  keypad_input_enables;
  logic [2:0]  periodic_interval_select;
  logic        keypad_interrupt_mask;
  logic        key_trigger_sensitivity;
  logic        periodic_pending_latch;
  logic        keypad_flag;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  a_ofs;
  logic        keypad_ack_strobe;
  logic        rd_stat;
  logic [8:0]  rc_div;
  logic        rc_tick;
  logic        ext_q;
  logic        osc_q;
  logic        ext_tick;
  logic        osc_tick;
  logic        period_hit;
  logic [3:0]  key_q;
  logic        key_edge;
  logic        key_level;
  logic        key_event;
  logic [31:0] next_rdata;

  function automatic logic is_reg(input logic [7:0] ofs, input logic [7:0] want);
    is_reg = (ofs == want);
  endfunction : is_reg

  // Bus: zero wait states, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_ofs   <= 8'h00;
    end else if (HREADY_I) begin
      wr_pend <= HSEL_I && HTRANS_I == `HTRANS_NONSEQ && HWRITE_I;
      rd_pend <= HSEL_I && HTRANS_I == `HTRANS_NONSEQ && !HWRITE_I;
      a_ofs   <= HADDR_I[7:0];
    end
  end

  assign keypad_ack_strobe = wr_pend && is_reg(a_ofs, `OFS_STATUS)
                             && HWDATA_I[`ST_ACK_BIT];
  assign rd_stat = rd_pend && is_reg(a_ofs, `OFS_IRQ_STAT);

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      periodic_clock_select     <= 2'h0;
      port_b_high_drive_enables <= 4'h0;
      keypad_input_enables      <= 4'h0;
      periodic_interval_select  <= 3'h0;
      keypad_interrupt_mask     <= 1'b0;
      key_trigger_sensitivity   <= 1'b0;
      irq_mask                  <= 2'h0;
    end else if (wr_pend) begin
      if (is_reg(a_ofs, `OFS_DRIVE)) begin
        periodic_clock_select     <= HWDATA_I[`DRV_CLK_LO +: 2];
        port_b_high_drive_enables <= HWDATA_I[`DRV_HD_LO +: 4];
      end
      if (is_reg(a_ofs, `OFS_ENABLE)) begin
        keypad_input_enables     <= HWDATA_I[`EN_KEY_LO +: 4];
        periodic_interval_select <= HWDATA_I[`EN_IVL_LO +: 3];
      end
      if (is_reg(a_ofs, `OFS_STATUS)) begin
        keypad_interrupt_mask   <= HWDATA_I[`ST_MASK_BIT];
        key_trigger_sensitivity <= HWDATA_I[`ST_MODE_BIT];
      end
      if (is_reg(a_ofs, `OFS_IRQ_MASK))
        irq_mask <= HWDATA_I[1:0];
    end
  end

  // Clock sources become enable pulses; RC rate is an approximation of 32 kHz
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      rc_div  <= 9'h000;
      rc_tick <= 1'b0;
    end else begin
      rc_tick <= (rc_div == 9'(RC_DIV - 1));
      rc_div  <= (rc_div == 9'(RC_DIV - 1)) ? 9'h000 : rc_div + 9'h001;
    end
  end

  // External clock sampled; at most half the bus rate is seen reliably
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      ext_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      ext_q <= EXT_CLK_I;
      osc_q <= OSC_CLK_I;
    end
  end
  assign ext_tick = EXT_CLK_I && !ext_q;
  assign osc_tick = OSC_CLK_I && !osc_q;

  // No low-power gating here: the counter runs in wait and stop alike
  period_counter u_counter (
    .clk_i      (MCLK_I),
    .rst_n_i    (NRST_I),
    .sel_i      (periodic_clock_select),
    .ivl_i      (periodic_interval_select),
    .rc_tick_i  (rc_tick),
    .ext_tick_i (ext_tick),
    .osc_tick_i (osc_tick),
    .hit_o      (period_hit)
  );

  // Set wins over acknowledge
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      periodic_pending_latch <= 1'b0;
    else if (period_hit)
      periodic_pending_latch <= 1'b1;
    else if (keypad_ack_strobe)
      periodic_pending_latch <= 1'b0;
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      key_q <= 4'hF;
    else
      key_q <= KEY_PINS_I;
  end
  assign key_edge  = |(keypad_input_enables & key_q & ~KEY_PINS_I);
  assign key_level = |(keypad_input_enables & ~KEY_PINS_I);
  assign key_event = key_edge || (key_trigger_sensitivity && key_level);

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      keypad_flag <= 1'b0;
    else if (key_event)
      keypad_flag <= 1'b1;
    else if (keypad_ack_strobe)
      keypad_flag <= 1'b0;
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      KEY_REQ_O <= 1'b0;
    else
      KEY_REQ_O <= (periodic_pending_latch || keypad_flag) && !keypad_interrupt_mask;
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      irq_stat <= 2'h0;
    else
      irq_stat <= (rd_stat ? 2'h0 : irq_stat) | {key_event, period_hit};
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_stat & irq_mask);
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      HIGH_DRIVE_O <= 4'h0;
    else
      HIGH_DRIVE_O <= port_b_high_drive_enables;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR_I[7:0])
      `OFS_DRIVE: begin
        next_rdata[`DRV_PEND_BIT]      = periodic_pending_latch;
        next_rdata[`DRV_HD_LO +: 4]    = port_b_high_drive_enables;
        next_rdata[`DRV_CLK_LO +: 2]   = periodic_clock_select;
      end
      `OFS_ENABLE: begin
        next_rdata[`EN_IVL_LO +: 3]    = periodic_interval_select;
        next_rdata[`EN_KEY_LO +: 4]    = keypad_input_enables;
      end
      `OFS_STATUS: begin
        next_rdata[`ST_FLAG_BIT]       = keypad_flag;
        next_rdata[`ST_ACK_BIT]        = 1'b0;
        next_rdata[`ST_MASK_BIT]       = keypad_interrupt_mask;
        next_rdata[`ST_MODE_BIT]       = key_trigger_sensitivity;
      end
      `OFS_IRQ_STAT: next_rdata[1:0]  = irq_stat;
      `OFS_IRQ_MASK: next_rdata[1:0]  = irq_mask;
      default:       next_rdata        = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!NRST_I)
      HRDATA_O <= 32'h0000_0000;
    else if (HREADY_I && HSEL_I && HTRANS_I == `HTRANS_NONSEQ && !HWRITE_I)
      HRDATA_O <= next_rdata;
  end

  sequence ack_write_s;
    keypad_ack_strobe && !period_hit;
  endsequence

  pend_set_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    period_hit |=> periodic_pending_latch) else $error("Latch not set");
  pend_ack_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    ack_write_s |=> !periodic_pending_latch) else $error("Latch not cleared");
  ack_key_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    (keypad_ack_strobe && !key_event) |=> !keypad_flag)
    else $error("Key request not cleared");
  ack_reads_zero_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    (HREADY_I && HSEL_I && HTRANS_I == `HTRANS_NONSEQ && !HWRITE_I
     && HADDR_I[7:0] == `OFS_STATUS) |=> !HRDATA_O[`ST_ACK_BIT])
    else $error("Ack read nonzero");
  req_or_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    ##1 KEY_REQ_O == $past((periodic_pending_latch || keypad_flag) && !keypad_interrupt_mask))
    else $error("Key request mismatch");
  level_mode_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    (key_trigger_sensitivity && key_level) |=> keypad_flag)
    else $error("Low level ignored");
  edge_only_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    (!key_trigger_sensitivity && !key_edge && !keypad_flag) |=> !keypad_flag)
    else $error("Flag without edge");
  pend_read_a: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    (HREADY_I && HSEL_I && HTRANS_I == `HTRANS_NONSEQ && !HWRITE_I
     && HADDR_I[7:0] == `OFS_DRIVE)
    |=> HRDATA_O[`DRV_PEND_BIT] == $past(periodic_pending_latch))
    else $error("Latch read wrong");
endmodule : periodic_interrupt_timer
`default_nettype wire

// ===== tb/clock_partner.sv
// Far-side clock sources: oscillator output and external periodic clock pin.
// Assumes the bus clock drives clk_i; both outputs are synchronous levels.
`timescale 1ns/10ps
`default_nettype none
module clock_partner (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      osc_o,
  output logic      ext_o
);
  logic [1:0] phase;
  // Free running, so no idle level to model
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign osc_o = phase[0];
  // Quarter rate keeps the pin well inside what the bus clock can sample
  assign ext_o = phase[1];
endmodule : clock_partner
`default_nettype wire

// ===== tb/periodic_interrupt_timer_bench.sv
// Self-checking bench for the periodic interrupt unit over AHB-Lite.
// Assumes a zero-wait slave; the RC source is too slow to run here.
`timescale 1ns/10ps
`default_nettype none
`include "periodic_defines.svh"
module periodic_interrupt_timer_bench;
  logic        mclk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        ext_clk;
  logic        osc_clk;
  logic [3:0]  key_pins;
  logic        key_req;
  logic [3:0]  high_drive;
  logic        irq;
  int          failures;
  int          n_compared;
  int          n;
  int          e;
  logic [31:0] rd;
  logic [1:0]  sels [3] = '{2'h2, 2'h1, 2'h2};
  logic [2:0]  ivls [3] = '{3'h1, 3'h1, 3'h2};
  logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

  periodic_interrupt_timer u_dut (
    .MCLK_I(mclk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
    .EXT_CLK_I(ext_clk), .OSC_CLK_I(osc_clk), .KEY_PINS_I(key_pins),
    .KEY_REQ_O(key_req), .HIGH_DRIVE_O(high_drive), .IRQ_O(irq)
  );
  clock_partner u_src (.clk_i(mclk), .rst_n_i(nrst), .osc_o(osc_clk), .ext_o(ext_clk));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Called just after an edge; holds each phase until hready is sampled
  task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr_en;
    hsize <= 3'h2;
    @(posedge mclk);
    // Only the watchdog ends a wait
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rdat = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask : rdc

  task wait_req(input int max);
    n = 0;
    while (key_req !== 1'b1 && n < max) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_req

  task in_rng(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask : in_rng

  // Interval zero first so every run starts from a cleared counter
  task run_period(input logic [1:0] sel, input logic [2:0] ivl, input logic [31:0] stat);
    wr(`OFS_ENABLE, 32'h0);
    wr(`OFS_STATUS, stat | 32'h4);
    wr(`OFS_DRIVE, {30'h0, sel});
    wr(`OFS_ENABLE, {25'h0, ivl, 4'h0});
  endtask : run_period

  initial begin
    repeat (50000) @(posedge mclk);
    failures++;
    test_done;
  end

  initial begin
    failures = 0;
    n_compared = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    key_pins = 4'hF;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (offs[i]) rdc(offs[i], 32'h0);
    wr(`OFS_IRQ_MASK, 32'h3);
    wr(`OFS_DRIVE, 32'h3E);
    rdc(`OFS_DRIVE, 32'h3E);
    check({28'h0, high_drive}, 32'hF);
    for (int i = 0; i < 3; i++) begin
      // No key input enabled, so edge-only sensitivity is acceptable
      run_period(sels[i], ivls[i], 32'h0);
      wait_req(5000);
      e = (2 ** (ivls[i] + 8)) * ((sels[i] == 2'h1) ? 4 : 2);
      in_rng(n, e - 8, e + 8);
    end
    check({31'h0, irq}, 32'h1);
    rdc(`OFS_DRIVE, 32'h82);
    wr(`OFS_DRIVE, 32'h02);
    rdc(`OFS_DRIVE, 32'h82);
    wr(`OFS_STATUS, 32'h4);
    rdc(`OFS_DRIVE, 32'h02);
    check({31'h0, key_req}, 32'h0);
    rdc(`OFS_STATUS, 32'h0);
    wait_req(5000);
    in_rng(n, 2020, 2046);
    rdc(`OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    run_period(2'h3, 3'h1, 32'h0);
    repeat (3000) @(posedge mclk);
    rdc(`OFS_DRIVE, 32'h03);
    run_period(2'h2, 3'h0, 32'h0);
    repeat (1200) @(posedge mclk);
    rdc(`OFS_DRIVE, 32'h02);
    check({31'h0, key_req}, 32'h0);
    run_period(2'h2, 3'h1, 32'h2);
    repeat (1100) @(posedge mclk);
    rdc(`OFS_DRIVE, 32'h82);
    check({31'h0, key_req}, 32'h0);
    wr(`OFS_STATUS, 32'h0);
    repeat (2) @(posedge mclk);
    check({31'h0, key_req}, 32'h1);
    run_period(2'h2, 3'h0, 32'h0);
    rdc(`OFS_IRQ_STAT, 32'h1);
    wr(`OFS_ENABLE, 32'h1);
    key_pins <= 4'hE;
    repeat (3) @(posedge mclk);
    rdc(`OFS_STATUS, 32'h8);
    check({31'h0, key_req}, 32'h1);
    wr(`OFS_STATUS, 32'h4);
    rdc(`OFS_STATUS, 32'h0);
    wr(`OFS_STATUS, 32'h5);
    repeat (2) @(posedge mclk);
    rdc(`OFS_STATUS, 32'h9);
    rdc(`OFS_IRQ_STAT, 32'h2);
    // Pin still low: input switched off before the acknowledge
    wr(`OFS_ENABLE, 32'h0);
    wr(`OFS_STATUS, 32'h5);
    rdc(`OFS_STATUS, 32'h1);
    key_pins <= 4'hF;
    test_done;
  end
endmodule : periodic_interrupt_timer_bench
`default_nettype wire
